// ===== core/vrs_pkg.sv
// Package of constants for the output reference slew and margin control block
package vrs_pkg;
    localparam logic [7:0] CMD_OPERATION     = 8'h01;
    localparam logic [7:0] CMD_MODE_SS       = 8'hD2;
    localparam logic [7:0] CMD_FINE_ADJUST   = 8'hD4;
    localparam logic [7:0] CMD_MARGIN_LEVELS = 8'hD5;
    localparam logic [7:0] CMD_UV_THRESHOLD  = 8'hD6;
    // Field positions
    localparam int SLEW_LSB    = 2;
    localparam int MHIGH_LSB   = 4;
    localparam int OP_MARG_LSB = 2;
    // Standard operation margin field codes (4-bit field at bits 5:2)
    localparam logic [3:0] OP_MARGIN_LOW  = 4'h5;
    localparam logic [3:0] OP_MARGIN_HIGH = 4'hA;
    // Reset values used if no stored copy is supplied
    localparam logic [7:0] RST_MODE_SS   = 8'h00;
    localparam logic [4:0] RST_FINE      = 5'h10;
    localparam logic [7:0] RST_MARGIN    = 8'h55;
    localparam logic [2:0] RST_UV        = 3'h5;
    localparam logic [7:0] RST_OPERATION = 8'h80;
    // Timing
    localparam int CLK_MHZ        = 200;
    localparam int APPLY_DELAY_US = 50;
    localparam int APPLY_DELAY_CYC = APPLY_DELAY_US * CLK_MHZ;
    localparam int STEP_BASE_US   = 4;
    localparam int STEP_BASE_CYC  = STEP_BASE_US * CLK_MHZ;
    // Scale: factors in units of 1/10000 (per ten thousand)
    localparam int PPM_ONE = 10000;
    typedef enum logic [1:0] {VRS_IDLE, VRS_WAIT, VRS_SLEW} vrs_state_t;
endpackage

// ===== core/vrs_ctrl.sv
// Reference target, margin and slew control behind the command write port
`timescale 1ns/1ps
module vrs_ctrl #(
    parameter int DAC_W        = 10,
    parameter int DAC_NOMINAL  = 512,
    parameter int APPLY_CYC    = vrs_pkg::APPLY_DELAY_CYC,
    parameter int STEP_CYC     = vrs_pkg::STEP_BASE_CYC
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             nvmLoad,
    input  wire logic [7:0]       nvmModeSs,
    input  wire logic [4:0]       nvmFine,
    input  wire logic [7:0]       nvmMargin,
    input  wire logic [2:0]       nvmUv,
    input  wire logic             cmdWrite,
    input  wire logic [7:0]       cmdCode,
    input  wire logic [7:0]       cmdData,
    input  wire logic             cmdRead,
    output logic [7:0]            readData,
    output logic [DAC_W-1:0]      dacCode,
    output logic [DAC_W-1:0]      targetCode,
    output logic                  slewBusy,
    output logic [2:0]            uvThresholdCode
);
    import vrs_pkg::*;

    localparam int CNT_W = 32;

    // Margin-high factor offsets in 1/10000
    function automatic int highOffset(input logic [3:0] c);
        case (c)
            4'h0: highOffset = 0;
            4'h1: highOffset = 90;
            4'h2: highOffset = 180;
            4'h3: highOffset = 280;
            4'h4: highOffset = 370;
            4'h5: highOffset = 470;
            4'h6: highOffset = 570;
            4'h7: highOffset = 670;
            4'h8: highOffset = 770;
            4'h9: highOffset = 880;
            4'hA: highOffset = 990;
            4'hB: highOffset = 1090;
            default: highOffset = 1200;
        endcase
    endfunction

    // Margin-low factor offsets in 1/10000, negative
    function automatic int lowOffset(input logic [3:0] c);
        case (c)
            4'h0: lowOffset = 0;
            4'h1: lowOffset = -110;
            4'h2: lowOffset = -210;
            4'h3: lowOffset = -320;
            4'h4: lowOffset = -420;
            4'h5: lowOffset = -520;
            4'h6: lowOffset = -620;
            4'h7: lowOffset = -710;
            4'h8: lowOffset = -810;
            4'h9: lowOffset = -900;
            4'hA: lowOffset = -990;
            4'hB: lowOffset = -1070;
            default: lowOffset = -1160;
        endcase
    endfunction

    // Fine adjust offset in 1/10000, 75 per code around 10000
    function automatic int fineOffset(input logic [4:0] c);
        int k;
        k = 0;
        if (c >= 5'h1C) begin
            k = 12;
        end else if (c >= 5'h10) begin
            k = int'(c) - 16;
        end else if (c <= 5'h03) begin
            k = -12;
        end else begin
            k = int'(c) - 15;
        end
        fineOffset = k * 75;
    endfunction

    logic [7:0]       modeSs_r, modeSs_nxt;
    logic [4:0]       fine_r, fine_nxt;
    logic [7:0]       margin_r, margin_nxt;
    logic [2:0]       uv_r, uv_nxt;
    logic [7:0]       oper_r, oper_nxt;
    logic [DAC_W-1:0] dac_r, dac_nxt;
    logic [DAC_W-1:0] tgt_r, tgt_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    vrs_state_t       st_r, st_nxt;
    logic [7:0]       rd_r, rd_nxt;
    logic [DAC_W-1:0] newTarget;
    logic             retarget;
    logic [CNT_W-1:0] stepLen;

    // Target from product of fine and margin factors
    always_comb begin
        longint fine;
        longint marg;
        longint prod;
        logic [3:0] sel;
        fine = '0;
        marg = '0;
        prod = '0;
        sel = oper_r[OP_MARG_LSB +: 4];
        fine = longint'(PPM_ONE + fineOffset(fine_r));
        if (sel == OP_MARGIN_HIGH) begin
            marg = longint'(PPM_ONE + highOffset(margin_r[MHIGH_LSB +: 4]));
        end else if (sel == OP_MARGIN_LOW) begin
            marg = longint'(PPM_ONE + lowOffset(margin_r[3:0]));
        end else begin
            marg = longint'(PPM_ONE);
        end
        prod = (longint'(DAC_NOMINAL) * fine * marg) / (PPM_ONE * PPM_ONE);
        if (prod > (2**DAC_W) - 1) begin
            prod = longint'((2**DAC_W) - 1);
        end
        newTarget = DAC_W'(prod);
    end

    // Step interval by slew select, 4us doubled per code
    assign stepLen = CNT_W'(STEP_CYC) << modeSs_r[SLEW_LSB +: 2];

    // Register writes, delayed retarget and slewing
    always_comb begin
        modeSs_nxt = modeSs_r;
        fine_nxt   = fine_r;
        margin_nxt = margin_r;
        uv_nxt     = uv_r;
        oper_nxt   = oper_r;
        dac_nxt    = dac_r;
        tgt_nxt    = tgt_r;
        cnt_nxt    = cnt_r;
        st_nxt     = st_r;
        retarget   = 1'b0;
        if (nvmLoad) begin
            // Stored settings loaded as initial values; the target follows only after the apply delay
            modeSs_nxt = nvmModeSs;
            fine_nxt   = nvmFine;
            margin_nxt = nvmMargin;
            uv_nxt     = nvmUv;
        end else if (cmdWrite) begin
            if (cmdCode == CMD_MODE_SS) begin
                modeSs_nxt = cmdData;
            end else if (cmdCode == CMD_FINE_ADJUST) begin
                fine_nxt = cmdData[4:0];
                retarget = 1'b1;
            end else if (cmdCode == CMD_MARGIN_LEVELS) begin
                margin_nxt = cmdData;
                retarget = 1'b1;
            end else if (cmdCode == CMD_UV_THRESHOLD) begin
                uv_nxt = cmdData[2:0];
            end else if (cmdCode == CMD_OPERATION) begin
                oper_nxt = cmdData;
                retarget = 1'b1;
            end
        end
        case (st_r)
            VRS_IDLE: begin
                if (dac_r != tgt_r) begin
                    cnt_nxt = '0;
                    st_nxt = VRS_SLEW;
                end
            end
            VRS_WAIT: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r >= CNT_W'(APPLY_CYC - 1)) begin
                    tgt_nxt = newTarget;
                    cnt_nxt = '0;
                    st_nxt = VRS_SLEW;
                end
            end
            VRS_SLEW: begin
                cnt_nxt = cnt_r + 1'b1;
                if (dac_r == tgt_r) begin
                    st_nxt = VRS_IDLE;
                end else if (cnt_r >= stepLen - 1'b1) begin
                    cnt_nxt = '0;
                    // One code per interval from the present value
                    if (dac_r < tgt_r) begin
                        dac_nxt = dac_r + 1'b1;
                    end else begin
                        dac_nxt = dac_r - 1'b1;
                    end
                end
            end
            default: st_nxt = VRS_IDLE;
        endcase
        if (retarget) begin
            // Delay restarts; DAC and target hold, even on a step edge
            dac_nxt = dac_r;
            tgt_nxt = tgt_r;
            cnt_nxt = '0;
            st_nxt = VRS_WAIT;
        end
        if (nvmLoad) begin
            dac_nxt = dac_r;
            tgt_nxt = dac_r;
            st_nxt = VRS_WAIT;
            cnt_nxt = '0;
        end
    end

    // Read-back of stored settings
    always_comb begin
        rd_nxt = rd_r;
        if (cmdRead) begin
            if (cmdCode == CMD_MODE_SS) begin
                rd_nxt = modeSs_r;
            end else if (cmdCode == CMD_FINE_ADJUST) begin
                rd_nxt = {3'h0, fine_r};
            end else if (cmdCode == CMD_MARGIN_LEVELS) begin
                rd_nxt = margin_r;
            end else if (cmdCode == CMD_UV_THRESHOLD) begin
                rd_nxt = {5'h00, uv_r};
            end else if (cmdCode == CMD_OPERATION) begin
                rd_nxt = oper_r;
            end else begin
                rd_nxt = 8'h00;
            end
        end
    end

    // State registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            modeSs_r <= RST_MODE_SS;
            fine_r   <= RST_FINE;
            margin_r <= RST_MARGIN;
            uv_r     <= RST_UV;
            oper_r   <= RST_OPERATION;
            dac_r    <= DAC_W'(DAC_NOMINAL);
            tgt_r    <= DAC_W'(DAC_NOMINAL);
            cnt_r    <= '0;
            st_r     <= VRS_IDLE;
            rd_r     <= 8'h00;
        end else begin
            modeSs_r <= modeSs_nxt;
            fine_r   <= fine_nxt;
            margin_r <= margin_nxt;
            uv_r     <= uv_nxt;
            oper_r   <= oper_nxt;
            dac_r    <= dac_nxt;
            tgt_r    <= tgt_nxt;
            cnt_r    <= cnt_nxt;
            st_r     <= st_nxt;
            rd_r     <= rd_nxt;
        end
    end

    assign readData        = rd_r;
    assign dacCode         = dac_r;
    assign targetCode      = tgt_r;
    assign slewBusy        = (st_r != VRS_IDLE);
    assign uvThresholdCode = uv_r;
endmodule

// ===== sim/vrs_ctrl_chk.sv
// Port checker for the reference slew and margin control
`timescale 1ns/1ps
module vrs_ctrl_chk #(
    parameter int DAC_W = 10
) (
    input wire logic             clk,
    input wire logic             rstn,
    input wire logic             nvmLoad,
    input wire logic             cmdWrite,
    input wire logic [7:0]       cmdCode,
    input wire logic [7:0]       cmdData,
    input wire logic             cmdRead,
    input wire logic [7:0]       readData,
    input wire logic [DAC_W-1:0] dacCode,
    input wire logic [DAC_W-1:0] targetCode,
    input wire logic             slewBusy,
    input wire logic [2:0]       uvThresholdCode
);
    import vrs_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Accepted write and the quiet spell after it
    sequence wrOf(logic [7:0] c);
        cmdWrite && !nvmLoad && cmdCode == c;
    endsequence
    sequence holdDac;
        $stable(dacCode) [*8];
    endsequence
    chk_single_step: assert property ($changed(dacCode) |->
        dacCode == $past(dacCode) + 1'b1 || dacCode == $past(dacCode) - 1'b1)
        else $error("dac moved more than one code");
    chk_toward_target: assert property ($changed(dacCode) |->
        (dacCode > $past(dacCode)) == ($past(targetCode) > $past(dacCode)))
        else $error("dac moved away from target");
    chk_fine_wait: assert property (wrOf(CMD_FINE_ADJUST) |=> holdDac)
        else $error("dac moved during apply delay");
    chk_margin_wait: assert property (wrOf(CMD_OPERATION) |=> holdDac)
        else $error("dac moved during margin delay");
    chk_step_gap: assert property ($changed(dacCode) |=> $stable(dacCode) [*3])
        else $error("dac step interval too short");
    chk_busy_start: assert property (wrOf(CMD_FINE_ADJUST) |=> slewBusy)
        else $error("busy not raised after write");
    chk_idle_match: assert property (!slewBusy |-> dacCode == targetCode)
        else $error("idle with dac off target");
    chk_target_hold: assert property (wrOf(CMD_MARGIN_LEVELS) |=>
        $stable(targetCode) [*8])
        else $error("target changed before delay end");
    chk_uv_load: assert property (wrOf(CMD_UV_THRESHOLD) |=>
        {5'h00, uvThresholdCode} == ($past(cmdData) & 8'h07))
        else $error("threshold code not loaded");
    chk_read_upper: assert property (cmdRead && cmdCode == CMD_UV_THRESHOLD |=>
        readData[7:3] == 5'h00)
        else $error("threshold upper bits not zero");
endmodule

// ===== sim/vrs_host_model.sv
// Bus host model issuing command writes and reads
`timescale 1ns/1ps
module vrs_host_model (
    input  wire logic  clk,
    output logic       cmdWrite,
    output logic [7:0] cmdCode,
    output logic [7:0] cmdData,
    output logic       cmdRead
);
    // Idle lines at time zero
    initial begin
        cmdWrite = 1'b0;
        cmdRead = 1'b0;
        cmdCode = 8'h00;
        cmdData = 8'h00;
    end
    // One byte write, data scrambled once released
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        @(posedge clk);
        cmdWrite <= 1'b1;
        cmdCode <= c;
        cmdData <= d;
        @(posedge clk);
        cmdWrite <= 1'b0;
        cmdData <= ~d;
    endtask
    // One readback request
    task automatic rd(input logic [7:0] c);
        @(posedge clk);
        cmdRead <= 1'b1;
        cmdCode <= c;
        @(posedge clk);
        cmdRead <= 1'b0;
        cmdCode <= ~c;
    endtask
endmodule

// ===== sim/tb_top.sv
// Top testbench for the reference slew and margin control
`timescale 1ns/1ps
module tb_top;
    import vrs_pkg::*;
    logic       clk = 1'b0, rstn = 1'b0, nvmLoad = 1'b0;
    logic [7:0] nvmModeSs = 8'h08, nvmMargin = 8'h55;
    logic [4:0] nvmFine = 5'h10;
    logic [2:0] nvmUv = 3'h6;
    logic       cmdWrite, cmdRead, slewBusy, readPend = 1'b0, busyOld = 1'b0;
    logic [7:0] cmdCode, cmdData, readData, d;
    logic [9:0] dacCode, targetCode, dacOld = 10'h200;
    logic [2:0] uvThresholdCode;
    logic [7:0] expRead[$];
    logic [9:0] expDac[$];
    logic [2:0] expUv[$];
    logic       uvPend = 1'b0;
    int         err_count = 0, n_compared = 0, cycles = 0, seed = 86854;
    int         lastChg = 0, lastGap = 0;
    always #2.5 clk = ~clk;
    vrs_ctrl #(.APPLY_CYC(20), .STEP_CYC(4)) vrs_ctrl_i (.clk, .rstn, .nvmLoad, .nvmModeSs,
        .nvmFine, .nvmMargin, .nvmUv, .cmdWrite, .cmdCode, .cmdData, .cmdRead, .readData,
        .dacCode, .targetCode, .slewBusy, .uvThresholdCode);
    vrs_host_model vrs_host_model_i (.clk, .cmdWrite, .cmdCode, .cmdData, .cmdRead);
    task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cmpDac(input string n, input logic [9:0] e, input logic [9:0] g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %0d got %0d", n, e, g);
        end
    endtask
    task automatic print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watcher: results taken off the queues as they appear
    always @(posedge clk) begin
        cycles <= cycles + 1;
        readPend <= cmdRead;
        uvPend <= cmdWrite && !nvmLoad && cmdCode == CMD_UV_THRESHOLD;
        busyOld <= slewBusy;
        dacOld <= dacCode;
        if (dacCode !== dacOld) begin
            lastGap <= cycles - lastChg;
            lastChg <= cycles;
        end
        if (readPend && expRead.size() > 0) cmp8("readData", expRead.pop_front(), readData);
        if (busyOld && !slewBusy && expDac.size() > 0) begin
            cmpDac("targetCode", expDac[0], targetCode);
            cmpDac("dacCode", expDac.pop_front(), dacCode);
        end
        if (uvPend && expUv.size() > 0) begin
            cmp8("uvCode", {5'h00, expUv.pop_front()}, {5'h00, uvThresholdCode});
        end
        if (cycles == 60000) begin
            err_count++;
            print_verdict;
        end
    end
    task automatic settle(input logic [9:0] e);
        int n;
        n = 0;
        expDac.push_back(e);
        repeat (3) @(posedge clk);
        while (slewBusy !== 1'b0 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 20000) begin
            err_count++;
            $display("MISMATCH slewBusy exp 0 got %b", slewBusy);
        end
        repeat (2) @(posedge clk);
    endtask
    task automatic rdChk(input logic [7:0] c, input logic [7:0] e);
        expRead.push_back(e);
        vrs_host_model_i.rd(c);
        repeat (2) @(posedge clk);
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        cmpDac("dacCode", 10'h200, dacCode);
        rdChk(CMD_MARGIN_LEVELS, 8'h55);
        rdChk(CMD_UV_THRESHOLD, 8'h05);
        rdChk(8'h33, 8'h00);
        vrs_host_model_i.wr(CMD_FINE_ADJUST, 8'hF4);
        settle(10'd527);
        cmp8("stepGap", 8'd4, lastGap[7:0]);
        vrs_host_model_i.wr(CMD_OPERATION, 8'hA8);
        settle(10'd552);
        vrs_host_model_i.wr(CMD_MODE_SS, 8'h0C);
        vrs_host_model_i.wr(CMD_MARGIN_LEVELS, 8'hC5);
        settle(10'd590);
        cmp8("stepGap", 8'd32, lastGap[7:0]);
        vrs_host_model_i.wr(CMD_OPERATION, 8'h94);
        settle(10'd499);
        vrs_host_model_i.wr(CMD_MODE_SS, 8'h00);
        vrs_host_model_i.wr(CMD_FINE_ADJUST, 8'h00);
        repeat (60) @(posedge clk);
        vrs_host_model_i.wr(CMD_FINE_ADJUST, 8'h1F);
        settle(10'd529);
        rdChk(CMD_FINE_ADJUST, 8'h1F);
        rdChk(CMD_OPERATION, 8'h94);
        for (int i = 0; i < 8; i++) begin
            if (i != 4) begin
                d = 8'($random(seed));
                d[2:0] = i[2:0];
                expUv.push_back(d[2:0]);
                vrs_host_model_i.wr(CMD_UV_THRESHOLD, d);
                rdChk(CMD_UV_THRESHOLD, {5'h00, d[2:0]});
            end
        end
        @(posedge clk);
        nvmLoad <= 1'b1;
        @(posedge clk);
        nvmLoad <= 1'b0;
        settle(10'd485);
        cmp8("stepGap", 8'd16, lastGap[7:0]);
        rdChk(CMD_MODE_SS, 8'h08);
        cmp8("uvCode", 8'h06, {5'h00, uvThresholdCode});
        print_verdict;
    end
endmodule
bind vrs_ctrl vrs_ctrl_chk #(.DAC_W(DAC_W)) vrs_ctrl_chk_i (.clk, .rstn, .nvmLoad, .cmdWrite,
    .cmdCode, .cmdData, .cmdRead, .readData, .dacCode, .targetCode, .slewBusy, .uvThresholdCode);
